// ===== design/sse_pkg.sv
// Shared constants for the skip/subtract/swap/table/xor execution unit.
// Assumes a classic Wishbone master with 32-bit data and byte addressing.
package sse_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_WORK = 8'h04;
    localparam logic [7:0] OFF_FLAGS = 8'h08;
    localparam logic [7:0] OFF_TLOW = 8'h0c;
    localparam logic [7:0] OFF_THIGH = 8'h10;
    localparam logic [7:0] OFF_TLATCH = 8'h14;
    localparam logic [7:0] OFF_MADDR = 8'h18;
    localparam logic [7:0] OFF_MDATA = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_PAGE = 8'h24;

    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BIT_LSB = 8;
    localparam int CMD_ADDR_LSB = 16;
    localparam int CMD_IMM_LSB = 24;

    // Flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;

    // Status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_SKIP = 1;
    localparam int ST_CYC_LSB = 4;

    // Reset values, increment step and full byte-select mask
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [3:0] SEL_ALL = 4'hf;

    typedef enum logic [3:0] {
        OP_INCR_SKIP_TO_WORK = 4'h0,
        OP_SKIP_BIT_SET = 4'h1,
        OP_MINUS_TO_WORK = 4'h2,
        OP_MINUS_TO_MEMORY = 4'h3,
        OP_MINUS_IMM = 4'h4,
        OP_NIBBLE_EXCHANGE = 4'h5,
        OP_NIBBLE_EXCHANGE_TO_WORK = 4'h6,
        OP_SKIP_ON_ZERO = 4'h7,
        OP_COPY_SKIP_ZERO = 4'h8,
        OP_SKIP_BIT_CLEAR = 4'h9,
        OP_TABLE_FETCH_PAGED = 4'ha,
        OP_TABLE_FETCH_CURRENT = 4'hb,
        OP_TABLE_FETCH_LAST = 4'hc,
        OP_EXCLUSIVE_OR_TO_WORK = 4'hd,
        OP_EXCLUSIVE_OR_TO_MEMORY = 4'he,
        OP_EXCLUSIVE_OR_IMM = 4'hf
    } sse_op_e;

    // Gray along idle -> exec -> dummy, exec -> idle and fetch -> idle; exec -> fetch and dummy -> idle flip two bits
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DUMMY = 2'b11,
        ST_TFETCH = 2'b10
    } sse_state_e;
endpackage

// ===== design/sse_exec_unit.sv
// Execution unit for skip, subtract, nibble swap, table read and xor instructions.
// Assumes a classic Wishbone master and a program memory that
// returns the addressed word in the same cycle as the read strobe.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Memory plus one to work, skip zero
// - Skip when selected memory bit set
// - Skip inserts dummy cycle, two cycles
// - Work minus memory to work, four flags
// - Work minus memory stored to memory
// - Work minus immediate to work, four flags
// - Carry clear on negative, else set
// - Swap memory nibbles in place, no flags
// - Swapped memory nibbles into work register
// - Skip when memory byte is zero
// - Copy memory to work, skip zero
// - Skip when selected memory bit clear
// - Table read via high and low pointers
// - Table read current page, low pointer
// - Table read last page, low pointer
// - Work xor memory to work, zero flag
// - Work xor memory to memory, zero flag
// - Work xor immediate to work, zero flag
module sse_exec_unit #(
    parameter int MEM_DEPTH = 128,
    parameter int PROG_AW = 11
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [PROG_AW-1:0] progAddr,
    output logic progRd,
    input wire logic [15:0] progData,
    output logic dummyCycle
);
    localparam int MEM_AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
    localparam int PAGE_W = PROG_AW - 8;
    localparam logic [7:0] RST_BYTE_W = sse_pkg::RST_BYTE;

    // Page arithmetic needs at least one page bit and at most 8-bit high pointer
    generate
        if (PROG_AW < 9 || PROG_AW > 16 || MEM_DEPTH < 2 || MEM_DEPTH > 256) begin : g_bad
            $error("sse_exec_unit: unsupported PROG_AW or MEM_DEPTH");
        end
    endgenerate

    function automatic logic [7:0] swapNibbles(input logic [7:0] v);
        swapNibbles = {v[3:0], v[7:4]};
    endfunction

    function automatic logic [MEM_AW-1:0] memIndex(input logic [7:0] a);
        memIndex = a[MEM_AW-1:0];
    endfunction

    // Architectural state
    logic [7:0] mem_reg [MEM_DEPTH];
    logic [7:0] work_reg;
    logic [3:0] flags_reg;
    logic [7:0] tableLowPointer_reg;
    logic [7:0] tableHighPointer_reg;
    logic [7:0] tableHighLatch_reg;
    logic [7:0] memAddr_reg;
    logic [7:0] curPage_reg;
    logic [3:0] op_reg;
    logic [2:0] bitSel_reg;
    logic [7:0] opAddr_reg;
    logic [7:0] imm_reg;
    logic lastSkip_reg;
    logic [1:0] cycles_reg;
    sse_pkg::sse_state_e state_reg;
    sse_pkg::sse_state_e state_next;
    logic [31:0] datO_reg;
    logic ack_reg;
    logic [PROG_AW-1:0] progAddr_reg;
    logic progRd_reg;
    logic dummy_reg;

    // Bus decode
    wire logic busReq = wb_cyc_i && wb_stb_i && !ack_reg;
    wire logic busWr = busReq && wb_we_i;
    wire logic lane0 = wb_sel_i[0];
    wire logic busy = (state_reg != sse_pkg::ST_IDLE);
    wire logic hitCmd = (wb_adr_i == sse_pkg::OFF_CMD);
    wire logic hitWork = (wb_adr_i == sse_pkg::OFF_WORK);
    wire logic hitFlags = (wb_adr_i == sse_pkg::OFF_FLAGS);
    wire logic hitTLow = (wb_adr_i == sse_pkg::OFF_TLOW);
    wire logic hitTHigh = (wb_adr_i == sse_pkg::OFF_THIGH);
    wire logic hitTLatch = (wb_adr_i == sse_pkg::OFF_TLATCH);
    wire logic hitMAddr = (wb_adr_i == sse_pkg::OFF_MADDR);
    wire logic hitMData = (wb_adr_i == sse_pkg::OFF_MDATA);
    wire logic hitStatus = (wb_adr_i == sse_pkg::OFF_STATUS);
    wire logic hitPage = (wb_adr_i == sse_pkg::OFF_PAGE);
    // Commands are refused while an instruction is still in flight
    wire logic startCmd = busWr && hitCmd && (wb_sel_i == sse_pkg::SEL_ALL) && !busy;

    // Operand fetch and arithmetic
    wire logic [7:0] memRd = mem_reg[memIndex(opAddr_reg)];
    wire logic [7:0] memView = mem_reg[memIndex(memAddr_reg)];
    wire logic isImm = (op_reg == sse_pkg::OP_MINUS_IMM)
        || (op_reg == sse_pkg::OP_EXCLUSIVE_OR_IMM);
    wire logic [7:0] operandB = isImm ? imm_reg : memRd;
    wire logic [8:0] diff = {1'b0, work_reg} - {1'b0, operandB};
    wire logic [4:0] nibDiff = {1'b0, work_reg[3:0]} - {1'b0, operandB[3:0]};
    wire logic [7:0] subRes = diff[7:0];
    wire logic subOv = (work_reg[7] ^ operandB[7]) && (work_reg[7] ^ subRes[7]);
    // No borrow means non-negative result, so carry is set
    wire logic [3:0] subFlags = {subOv, (subRes == 8'h00), !nibDiff[4], !diff[8]};
    wire logic [7:0] xorRes = work_reg ^ operandB;
    wire logic [7:0] incRes = memRd + sse_pkg::ONE_BYTE;
    wire logic selBit = memRd[bitSel_reg];
    wire logic [7:0] lastPage = '1;
    wire logic [PAGE_W-1:0] pagePaged = tableHighPointer_reg[PAGE_W-1:0];
    wire logic [PAGE_W-1:0] pageCur = curPage_reg[PAGE_W-1:0];
    wire logic [PAGE_W-1:0] pageLast = lastPage[PAGE_W-1:0];

    // Per-instruction effects, valid in the execute cycle
    logic exWork;
    logic [7:0] exWorkVal;
    logic exMem;
    logic [7:0] exMemVal;
    logic exFlags;
    logic [3:0] exFlagsVal;
    logic exSkip;
    logic exTable;
    logic [PROG_AW-1:0] exTableAddr;
    always_comb begin
        exWork = 1'b0;
        exWorkVal = RST_BYTE_W;
        exMem = 1'b0;
        exMemVal = memRd;
        exFlags = 1'b0;
        exFlagsVal = flags_reg;
        exSkip = 1'b0;
        exTable = 1'b0;
        exTableAddr = {pagePaged, tableLowPointer_reg};
        case (op_reg)
            sse_pkg::OP_INCR_SKIP_TO_WORK: begin
                exWork = 1'b1;
                exWorkVal = incRes;
                exSkip = (incRes == 8'h00);
            end
            sse_pkg::OP_SKIP_BIT_SET: begin
                exSkip = selBit;
            end
            sse_pkg::OP_MINUS_TO_WORK, sse_pkg::OP_MINUS_IMM: begin
                exWork = 1'b1;
                exWorkVal = subRes;
                exFlags = 1'b1;
                exFlagsVal = subFlags;
            end
            sse_pkg::OP_MINUS_TO_MEMORY: begin
                exMem = 1'b1;
                exMemVal = subRes;
                exFlags = 1'b1;
                exFlagsVal = subFlags;
            end
            sse_pkg::OP_NIBBLE_EXCHANGE: begin
                exMem = 1'b1;
                exMemVal = swapNibbles(memRd);
            end
            sse_pkg::OP_NIBBLE_EXCHANGE_TO_WORK: begin
                exWork = 1'b1;
                exWorkVal = swapNibbles(memRd);
            end
            sse_pkg::OP_SKIP_ON_ZERO: begin
                exSkip = (memRd == 8'h00);
            end
            sse_pkg::OP_COPY_SKIP_ZERO: begin
                exWork = 1'b1;
                exWorkVal = memRd;
                exSkip = (memRd == 8'h00);
            end
            sse_pkg::OP_SKIP_BIT_CLEAR: begin
                exSkip = !selBit;
            end
            sse_pkg::OP_TABLE_FETCH_PAGED: begin
                exTable = 1'b1;
                exTableAddr = {pagePaged, tableLowPointer_reg};
            end
            sse_pkg::OP_TABLE_FETCH_CURRENT: begin
                exTable = 1'b1;
                exTableAddr = {pageCur, tableLowPointer_reg};
            end
            sse_pkg::OP_TABLE_FETCH_LAST: begin
                exTable = 1'b1;
                exTableAddr = {pageLast, tableLowPointer_reg};
            end
            sse_pkg::OP_EXCLUSIVE_OR_TO_WORK, sse_pkg::OP_EXCLUSIVE_OR_IMM: begin
                exWork = 1'b1;
                exWorkVal = xorRes;
                exFlags = 1'b1;
                exFlagsVal = flags_reg;
                exFlagsVal[sse_pkg::FLG_Z] = (xorRes == 8'h00);
            end
            sse_pkg::OP_EXCLUSIVE_OR_TO_MEMORY: begin
                exMem = 1'b1;
                exMemVal = xorRes;
                exFlags = 1'b1;
                exFlagsVal = flags_reg;
                exFlagsVal[sse_pkg::FLG_Z] = (xorRes == 8'h00);
            end
            default: begin
                exSkip = 1'b0;
            end
        endcase
    end

    // Sequencing: skip takes a dummy cycle, table read a fetch cycle
    wire logic inExec = (state_reg == sse_pkg::ST_EXEC);
    wire logic inFetch = (state_reg == sse_pkg::ST_TFETCH);
    always_comb begin
        case (state_reg)
            sse_pkg::ST_IDLE: state_next = startCmd ? sse_pkg::ST_EXEC : sse_pkg::ST_IDLE;
            sse_pkg::ST_EXEC: begin
                if (exTable) begin
                    state_next = sse_pkg::ST_TFETCH;
                end else if (exSkip) begin
                    state_next = sse_pkg::ST_DUMMY;
                end else begin
                    state_next = sse_pkg::ST_IDLE;
                end
            end
            sse_pkg::ST_DUMMY: state_next = sse_pkg::ST_IDLE;
            sse_pkg::ST_TFETCH: state_next = sse_pkg::ST_IDLE;
            default: state_next = sse_pkg::ST_IDLE;
        endcase
    end

    // Memory and work writers; instruction wins over the bus
    wire logic memWrEx = inExec && exMem;
    wire logic memWrTbl = inFetch;
    wire logic memWrBus = busWr && hitMData && lane0;
    wire logic [MEM_AW-1:0] memWrIdx = (memWrEx || memWrTbl) ? memIndex(opAddr_reg)
                                                              : memIndex(memAddr_reg);
    wire logic [7:0] memWrVal = memWrEx ? exMemVal :
                                (memWrTbl ? progData[7:0] : wb_dat_i[7:0]);
    wire logic memWrAny = memWrEx || memWrTbl || memWrBus;

    // Read-back mux
    wire logic [31:0] statusWord = {24'h000000, 2'b00, cycles_reg, 2'b00, lastSkip_reg, busy};
    wire logic [31:0] cmdWord = {imm_reg, opAddr_reg, 5'h00, bitSel_reg, 4'h0, op_reg};
    wire logic [31:0] rdMux = hitCmd ? cmdWord :
                              hitWork ? {24'h000000, work_reg} :
                              hitFlags ? {28'h0000000, flags_reg} :
                              hitTLow ? {24'h000000, tableLowPointer_reg} :
                              hitTHigh ? {24'h000000, tableHighPointer_reg} :
                              hitTLatch ? {24'h000000, tableHighLatch_reg} :
                              hitMAddr ? {24'h000000, memAddr_reg} :
                              hitMData ? {24'h000000, memView} :
                              hitStatus ? statusWord :
                              hitPage ? {24'h000000, curPage_reg} : 32'h00000000;

    // Data memory storage, no reset as in the real array
    genvar gi;
    generate
        for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
            always_ff @(posedge clk) begin
                if (memWrAny && (memWrIdx == MEM_AW'(gi))) begin
                    mem_reg[gi] <= memWrVal;
                end
            end
        end
    endgenerate

    // Bus slave: ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
            datO_reg <= 32'h00000000;
        end else begin
            ack_reg <= busReq;
            datO_reg <= busReq ? rdMux : datO_reg;
        end
    end

    // Command capture
    always_ff @(posedge clk) begin
        if (srst) begin
            op_reg <= 4'h0;
            bitSel_reg <= 3'h0;
            opAddr_reg <= sse_pkg::RST_BYTE;
            imm_reg <= sse_pkg::RST_BYTE;
        end else if (startCmd) begin
            op_reg <= wb_dat_i[sse_pkg::CMD_OP_LSB +: 4];
            bitSel_reg <= wb_dat_i[sse_pkg::CMD_BIT_LSB +: 3];
            opAddr_reg <= wb_dat_i[sse_pkg::CMD_ADDR_LSB +: 8];
            imm_reg <= wb_dat_i[sse_pkg::CMD_IMM_LSB +: 8];
        end
    end

    // Work register and flags
    always_ff @(posedge clk) begin
        if (srst) begin
            work_reg <= sse_pkg::RST_BYTE;
            flags_reg <= sse_pkg::RST_FLAGS;
        end else begin
            if (inExec && exWork) begin
                work_reg <= exWorkVal;
            end else if (busWr && hitWork && lane0) begin
                work_reg <= wb_dat_i[7:0];
            end
            if (inExec && exFlags) begin
                flags_reg <= exFlagsVal;
            end else if (busWr && hitFlags && lane0) begin
                flags_reg <= wb_dat_i[3:0];
            end
        end
    end

    // Table pointers, latch and software-held page
    always_ff @(posedge clk) begin
        if (srst) begin
            tableLowPointer_reg <= sse_pkg::RST_BYTE;
            tableHighPointer_reg <= sse_pkg::RST_BYTE;
            tableHighLatch_reg <= sse_pkg::RST_BYTE;
            memAddr_reg <= sse_pkg::RST_BYTE;
            curPage_reg <= sse_pkg::RST_BYTE;
        end else begin
            if (busWr && hitTLow && lane0) begin
                tableLowPointer_reg <= wb_dat_i[7:0];
            end
            if (busWr && hitTHigh && lane0) begin
                tableHighPointer_reg <= wb_dat_i[7:0];
            end
            if (inFetch) begin
                tableHighLatch_reg <= progData[15:8];
            end
            if (busWr && hitMAddr && lane0) begin
                memAddr_reg <= wb_dat_i[7:0];
            end
            if (busWr && hitPage && lane0) begin
                curPage_reg <= wb_dat_i[7:0];
            end
        end
    end

    // Sequencer, program read strobe, dummy marker, cycle count
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= sse_pkg::ST_IDLE;
            progAddr_reg <= '0;
            progRd_reg <= 1'b0;
            dummy_reg <= 1'b0;
            lastSkip_reg <= 1'b0;
            cycles_reg <= sse_pkg::CYC_ONE;
        end else begin
            state_reg <= state_next;
            progRd_reg <= inExec && exTable;
            progAddr_reg <= (inExec && exTable) ? exTableAddr : progAddr_reg;
            dummy_reg <= inExec && exSkip && !exTable;
            lastSkip_reg <= inExec ? exSkip : lastSkip_reg;
            if (inExec) begin
                cycles_reg <= sse_pkg::CYC_ONE;
            end else if (state_reg == sse_pkg::ST_DUMMY || inFetch) begin
                cycles_reg <= cycles_reg + 2'h1;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = datO_reg;
    assign progAddr = progAddr_reg;
    assign progRd = progRd_reg;
    assign dummyCycle = dummy_reg;
endmodule

`default_nettype wire

// ===== tb/sse_exec_checker.sv
// Port checker for the execution unit: bus answer, skip and table timing.
// Assumes it is bound to sse_exec_unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module sse_exec_checker #(
    parameter int PROG_AW = 11
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [PROG_AW-1:0] progAddr,
    input wire logic progRd,
    input wire logic [15:0] progData,
    input wire logic dummyCycle
);
    wire logic cmdTake;
    wire logic skipOp;
    wire logic tableOp;
    wire logic lastOp;

    // Command write taken at this edge, sorted by opcode class
    assign cmdTake = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == sse_pkg::OFF_CMD && wb_sel_i == sse_pkg::SEL_ALL;
    assign skipOp = cmdTake && (wb_dat_i[3:0] inside {4'h0, 4'h1, 4'h7, 4'h8, 4'h9});
    assign tableOp = cmdTake && (wb_dat_i[3:0] inside {4'ha, 4'hb, 4'hc});
    assign lastOp = cmdTake && wb_dat_i[3:0] == 4'hc;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Bus answer comes one cycle after the request, for one cycle only
    ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");

    // Dummy cycle only two cycles after a skipping command, one cycle long
    dummy_single_a: assert property (dummyCycle |=> !dummyCycle)
        else $error("dummy cycle too long");
    skip_cause_a: assert property (dummyCycle |-> $past(skipOp, 2))
        else $error("dummy cycle without skip command");

    // Table reads strobe program memory exactly two cycles after the command
    table_run_a: assert property (tableOp |-> ##2 progRd)
        else $error("table read strobe missing");
    prog_cause_a: assert property (progRd |-> $past(tableOp, 2))
        else $error("program read without table command");
    prog_hold_a: assert property (progRd |=> !progRd && $stable(progAddr))
        else $error("program read strobe or address unsettled");
    last_page_a: assert property (lastOp |-> ##2 (progRd && &progAddr[PROG_AW-1:8]))
        else $error("last page read not on top page");
endmodule

`default_nettype wire

// ===== tb/sse_exec_unit_tb.sv
// Self-checking bench for the execution unit: instruction rows, then table
// reads, a refused command, an unmapped read and a second reset.
// Assumes sse_pkg, sse_exec_unit and sse_exec_checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module sse_exec_unit_tb;
    typedef struct packed {
        logic [3:0] op;
        logic [2:0] bitSel;
        logic [7:0] imm, work0, mem0, expWork, expMem;
        logic [3:0] fl0, expFl;
        logic skip;
    } sse_row_s;

    // op, bit, imm, work, mem, expected work, expected mem, flags in, flags out, skip
    localparam sse_row_s ROWS [19] = '{
        '{4'h0, 3'h0, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 4'hb, 4'hb, 1'b1},
        '{4'h0, 3'h0, 8'h00, 8'h00, 8'h41, 8'h42, 8'h41, 4'hb, 4'hb, 1'b0},
        '{4'h1, 3'h7, 8'h00, 8'h33, 8'h80, 8'h33, 8'h80, 4'hb, 4'hb, 1'b1},
        '{4'h1, 3'h0, 8'h00, 8'h33, 8'hfe, 8'h33, 8'hfe, 4'hb, 4'hb, 1'b0},
        '{4'h2, 3'h0, 8'h00, 8'h10, 8'h20, 8'hf0, 8'h20, 4'h0, 4'h2, 1'b0},
        '{4'h2, 3'h0, 8'h00, 8'h80, 8'h01, 8'h7f, 8'h01, 4'h0, 4'h9, 1'b0},
        '{4'h3, 3'h0, 8'h00, 8'h55, 8'h55, 8'h55, 8'h00, 4'h0, 4'h7, 1'b0},
        '{4'h4, 3'h0, 8'h06, 8'h05, 8'h11, 8'hff, 8'h11, 4'hf, 4'h0, 1'b0},
        '{4'h5, 3'h0, 8'h00, 8'h33, 8'ha5, 8'h33, 8'h5a, 4'hb, 4'hb, 1'b0},
        '{4'h6, 3'h0, 8'h00, 8'h33, 8'h3c, 8'hc3, 8'h3c, 4'hb, 4'hb, 1'b0},
        '{4'h7, 3'h0, 8'h00, 8'h33, 8'h00, 8'h33, 8'h00, 4'hb, 4'hb, 1'b1},
        '{4'h7, 3'h0, 8'h00, 8'h33, 8'h01, 8'h33, 8'h01, 4'hb, 4'hb, 1'b0},
        '{4'h8, 3'h0, 8'h00, 8'h77, 8'h00, 8'h00, 8'h00, 4'hb, 4'hb, 1'b1},
        '{4'h8, 3'h0, 8'h00, 8'h77, 8'h9e, 8'h9e, 8'h9e, 4'hb, 4'hb, 1'b0},
        '{4'h9, 3'h3, 8'h00, 8'h33, 8'hf7, 8'h33, 8'hf7, 4'hb, 4'hb, 1'b1},
        '{4'h9, 3'h3, 8'h00, 8'h33, 8'h08, 8'h33, 8'h08, 4'hb, 4'hb, 1'b0},
        '{4'hd, 3'h0, 8'h00, 8'hf0, 8'hf0, 8'h00, 8'hf0, 4'hb, 4'hf, 1'b0},
        '{4'he, 3'h0, 8'h00, 8'h0f, 8'hf0, 8'h0f, 8'hff, 4'hf, 4'hb, 1'b0},
        '{4'hf, 3'h0, 8'h55, 8'haa, 8'h11, 8'hff, 8'h11, 4'h4, 4'h0, 1'b0}
    };
    localparam logic [7:0] MEM_ADR = 8'h2a;

    logic clk, srst, wbCyc, wbStb, wbWe, wbAck, progRd, dummyCycle;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO;
    logic [10:0] progAddr, lastAddr;
    logic [15:0] progData;
    int nFail, testsRun, dmyCount, dmyBase;

    // Program memory: word derived from its own address, always valid
    assign progData = {5'h15, progAddr};

    sse_exec_unit i_dut (
        .clk(clk),
        .srst(srst),
        .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb),
        .wb_we_i(wbWe),
        .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck),
        .progAddr(progAddr),
        .progRd(progRd),
        .progData(progData),
        .dummyCycle(dummyCycle)
    );

    always #5 clk = ~clk;

    // Count dummy cycles and keep the last table address
    always @(posedge clk) begin
        dmyCount <= dmyCount + int'(dummyCycle === 1'b1);
        if (progRd === 1'b1)
            lastAddr <= progAddr;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nFail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One classic access, held until ack is sampled, then a gap cycle
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
            input logic [3:0] sel, output logic [31:0] rdat);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatI <= dat;
        do
            @(posedge clk);
        while (wbAck !== 1'b1);
        rdat = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wbXfer(1'b1, adr, dat, 4'hf, d);
    endtask

    task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wbXfer(1'b0, adr, 32'h0, 4'hf, d);
        check(d, exp);
    endtask

    // Start an instruction; polling busy avoids a refused next command
    task automatic runCmd(input logic [31:0] cmd, input logic [3:0] sel);
        logic [31:0] d;
        wbXfer(1'b1, sse_pkg::OFF_CMD, cmd, sel, d);
        do
            wbXfer(1'b0, sse_pkg::OFF_STATUS, 32'h0, 4'hf, d);
        while (d[sse_pkg::ST_BUSY] !== 1'b0);
    endtask

    // Two-cycle reset, then the cleared state
    task automatic doReset();
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rdChk(sse_pkg::OFF_WORK, 32'h0);
        rdChk(sse_pkg::OFF_FLAGS, 32'h0);
        rdChk(sse_pkg::OFF_STATUS, 32'h10);
        rdChk(sse_pkg::OFF_TLATCH, 32'h0);
    endtask

    task automatic completeRun();
        if (nFail == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog well beyond the roughly 700 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        completeRun();
    end

    initial begin
        sse_row_s r;
        logic [2:0] pg;
        clk = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatI = 32'h0;
        doReset();
        // Instruction rows: preload, run, read back every result
        for (int i = 0; i < 19; i++) begin
            r = ROWS[i];
            wr(sse_pkg::OFF_WORK, {24'h0, r.work0});
            wr(sse_pkg::OFF_FLAGS, {28'h0, r.fl0});
            wr(sse_pkg::OFF_MADDR, {24'h0, MEM_ADR});
            wr(sse_pkg::OFF_MDATA, {24'h0, r.mem0});
            dmyBase = dmyCount;
            runCmd({r.imm, MEM_ADR, 5'h0, r.bitSel, 4'h0, r.op}, 4'hf);
            rdChk(sse_pkg::OFF_WORK, {24'h0, r.expWork});
            rdChk(sse_pkg::OFF_MDATA, {24'h0, r.expMem});
            rdChk(sse_pkg::OFF_FLAGS, {28'h0, r.expFl});
            rdChk(sse_pkg::OFF_STATUS, {26'h0, r.skip, !r.skip, 2'h0, r.skip, 1'b0});
            check(32'(dmyCount - dmyBase), {31'h0, r.skip});
        end
        // Table reads on three pages; never a skip
        wr(sse_pkg::OFF_TLOW, 32'h3c);
        wr(sse_pkg::OFF_THIGH, 32'h05);
        wr(sse_pkg::OFF_PAGE, 32'h02);
        for (int k = 0; k < 3; k++) begin
            pg = (k == 0) ? 3'h5 : ((k == 1) ? 3'h2 : 3'h7);
            dmyBase = dmyCount;
            runCmd({8'h0, MEM_ADR, 12'h0, 4'ha + 4'(k)}, 4'hf);
            check({21'h0, lastAddr}, {21'h0, pg, 8'h3c});
            rdChk(sse_pkg::OFF_MDATA, 32'h3c);
            rdChk(sse_pkg::OFF_TLATCH, {24'h0, 5'h15, pg});
            check(32'(dmyCount - dmyBase), 32'h0);
        end
        // Partial-lane command refused, unmapped and read-only places
        wr(sse_pkg::OFF_WORK, 32'h12);
        runCmd({8'h0, MEM_ADR, 12'h0, 4'h6}, 4'h1);
        rdChk(sse_pkg::OFF_WORK, 32'h12);
        rdChk(sse_pkg::OFF_CMD, {8'h0, MEM_ADR, 12'h0, 4'hc});
        rdChk(8'h3c, 32'h0);
        wr(sse_pkg::OFF_STATUS, 32'h3);
        rdChk(sse_pkg::OFF_STATUS, 32'h20);
        // Second reset in mid-run
        wr(sse_pkg::OFF_WORK, 32'h5a);
        doReset();
        completeRun();
    end
endmodule

bind sse_exec_unit sse_exec_checker #(.PROG_AW(PROG_AW)) i_chk (
    .clk(clk),
    .srst(srst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .progAddr(progAddr),
    .progRd(progRd),
    .progData(progData),
    .dummyCycle(dummyCycle)
);

`default_nettype wire
